// File: hdl/flash_host.sv
`timescale 1ns/1ps
// Notes on behaviour
// RULE_01: At most four partial programs per page.
// RULE_02: Feature operations finish within one microsecond.
// RULE_03: OTP protect feature busy up to 800us.
// RULE_04: Protected or OTP program busy up to 800us.
// RULE_05: Copy-back pages share odd/even parity.
// RULE_06: Command latched with command latch high.
// RULE_07: Write-lock high for program and erase phases.
// RULE_08: Address latched with address latch high.
// RULE_09: Data latched with both latches low.
// RULE_10: Issue read command after status-polled read.
// RULE_11: Same for secondary identification reads.
// RULE_12: Spare area split in four regions.
// RULE_13: Main and spare randomized differently.
// RULE_14: Load main, jump to spare, jump back.
// RULE_15: Each main segment pairs only its spare.
// RULE_16: Main and spare in same partial program.
// RULE_17: Read back main first, then spare.
// RULE_18: Small loads carry at least four bytes.
// RULE_19: Small loads start on four-byte column.
// RULE_20: First command after power-on is reset.
// RULE_21: Reset while ready busy at most 5us.
// RULE_22: Ready line low during every busy operation.
module flash_host
  import flash_host_pkg::*;
#(
  parameter int PROG_TO_CYC = PROG_CYC,
  parameter int OTP_TO_CYC = OTP_CYC,
  parameter int ERASE_TO_CYC = BERS_CYC,
  parameter int READ_TO_CYC = READ_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Software register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // Flash pins
  output pins_t pins,
  output logic [7:0] io_out,
  output logic io_oe,
  input wire logic [7:0] io_in,
  input wire logic rb_n
);
  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  function automatic logic is_busy_cmd(input logic [7:0] c);
    return c == CMD_READ_GO || c == CMD_COPY_READ_GO || c == CMD_PROG_GO || c == CMD_ERASE_GO
      || c == CMD_RESET || c == CMD_SET_FEAT || c == CMD_GET_FEAT;
  endfunction

  function automatic logic is_modify_cmd(input logic [7:0] c);
    return c == CMD_PROG || c == CMD_COL_IN || c == CMD_PROG_GO || c == CMD_ERASE || c == CMD_ERASE_GO;
  endfunction

  // Spare flag and segment number of a column; spare regions follow the main area
  function automatic logic [2:0] seg_of(input logic [15:0] c);
    if (int'(c) >= MAIN_BYTES) begin
      return {1'b1, 2'((int'(c) - MAIN_BYTES) / SPARE_SEG_BYTES)}; // RULE_12
    end
    return {1'b0, 2'(int'(c) / SEG_BYTES)};
  endfunction

  typedef enum {S_IDLE, S_HOLD, S_SETUP, S_LOW, S_HIGH, S_GAP, S_BUSY} state_t;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  state_t state_reg;
  op_t op_reg;
  logic pend_dout_reg;
  logic [7:0] ph_reg;
  logic [23:0] to_reg;
  logic [2:0] ctrl_reg;
  logic [NUM_ERR-1:0] err_reg;
  logic reset_done_reg;
  logic [7:0] cur_cmd_reg;
  logic [1:0] addr_idx_reg;
  logic [15:0] col_reg;
  logic [15:0] row_reg;
  logic [15:0] pp_row_reg;
  logic [2:0] pp_cnt_reg;
  logic [12:0] load_cnt_reg;
  logic [1:0] main_seg_reg;
  logic main_seen_reg;
  logic spare_seen_reg;
  logic cb_mode_reg;
  logic src_par_reg;
  logic read_pend_reg;
  logic last_status_reg;
  logic [7:0] dout_reg;
  pins_t pins_next;
  logic [7:0] io_next;
  logic oe_next;

  // ----------------------------------------------------------------
  // Request decode and refusal
  // ----------------------------------------------------------------
  wire seq_busy = state_reg != S_IDLE;
  wire sw_cmd = wr && addr == REG_CMD;
  wire sw_addr = wr && addr == REG_ADDR;
  wire sw_din = wr && addr == REG_DATA;
  wire sw_dout = wr && addr == REG_RDREQ;
  wire [7:0] wbyte = wdata[7:0];
  wire need_auto = sw_dout && read_pend_reg && last_status_reg; // RULE_10 RULE_11
  wire same_page = row_reg == pp_row_reg;
  wire ref_reset = sw_cmd && !reset_done_reg && wbyte != CMD_RESET; // RULE_20
  wire ref_wp = (sw_cmd || sw_addr || sw_din) && !ctrl_reg[CTRL_WP]
    && (is_modify_cmd(sw_cmd ? wbyte : cur_cmd_reg)); // RULE_07
  wire ref_pp = sw_cmd && wbyte == CMD_PROG_GO && same_page
    && int'(pp_cnt_reg) >= PP_MAX; // RULE_01
  wire ref_size = sw_cmd && wbyte == CMD_PROG_GO && int'(load_cnt_reg) < SMALL_MIN; // RULE_18
  wire refuse = ref_reset || ref_wp || ref_pp || ref_size;
  wire req = sw_cmd || sw_addr || sw_din || sw_dout;
  wire accept = req && !seq_busy && !refuse;
  wire acc_cmd = accept && sw_cmd;
  wire acc_addr = accept && sw_addr;
  wire acc_din = accept && sw_din;
  wire [2:0] col_seg = seg_of({wbyte, col_reg[7:0]});
  wire col_done = acc_addr && addr_idx_reg == 2'(COL_BYTES - 1);
  wire in_prog = cur_cmd_reg == CMD_PROG || cur_cmd_reg == CMD_COL_IN;
  wire spare_jump = col_done && in_prog && col_seg[2];
  wire bad_pair_jump = spare_jump && col_seg[1:0] != main_seg_reg; // RULE_15 RULE_17
  wire bad_align = col_done && in_prog && col_reg[1:0] != 2'h0; // RULE_19
  wire prog_go = acc_cmd && wbyte == CMD_PROG_GO;
  wire bad_unpaired = prog_go && !(main_seen_reg && spare_seen_reg); // RULE_16
  wire bad_parity = prog_go && cb_mode_reg && src_par_reg != row_reg[0]; // RULE_05
  wire seg_spare = seg_of(col_reg) >= 3'h4;
  wire timeout = state_reg == S_BUSY && !rb_n && to_reg == 24'h0;

  // Longest busy time for the command in flight; OTP work stretches both
  // program and set-feature busy time, so software marks it in control
  wire otp = ctrl_reg[CTRL_OTP];
  wire [7:0] oc = op_reg.data;
  wire [23:0] busy_limit =
    (oc == CMD_RESET) ? RST_CYC : // RULE_21
    (oc == CMD_SET_FEAT && otp) ? 24'(OTP_TO_CYC) : // RULE_03
    (oc == CMD_SET_FEAT || oc == CMD_GET_FEAT) ? FEAT_CYC : // RULE_02
    (oc == CMD_PROG_GO && otp) ? 24'(OTP_TO_CYC) : // RULE_04
    (oc == CMD_PROG_GO) ? 24'(PROG_TO_CYC) :
    (oc == CMD_ERASE_GO) ? 24'(ERASE_TO_CYC) : 24'(READ_TO_CYC);

  wire [NUM_ERR-1:0] err_set = {timeout, bad_parity, bad_pair_jump || bad_unpaired, bad_align,
    ref_size && !seq_busy, ref_pp && !seq_busy, ref_wp && !seq_busy, ref_reset && !seq_busy};
  wire [NUM_ERR-1:0] err_clr = (wr && addr == REG_STATUS) ? wdata[ERR_LSB +: NUM_ERR] : '0;

  wire [31:0] status_word = {16'h0, err_reg, 1'b0, pp_cnt_reg, read_pend_reg, reset_done_reg,
    rb_n, seq_busy};
  wire [31:0] rd_mux =
    (addr == REG_DATA) ? {24'h0, dout_reg} :
    (addr == REG_CTRL) ? {29'h0, ctrl_reg} :
    (addr == REG_STATUS) ? status_word : 32'h0;

  // ----------------------------------------------------------------
  // Pin drive, decoded from the sequencer state; chip enable and write-lock come from control
  // ----------------------------------------------------------------
  wire active = state_reg == S_SETUP || state_reg == S_LOW || state_reg == S_HIGH;
  wire strobe = state_reg == S_LOW;
  wire is_out = op_reg.kind == OP_DOUT;
  always_comb begin
    pins_next.ce_n = !ctrl_reg[CTRL_CE];
    pins_next.cle = active && op_reg.kind == OP_CMD; // RULE_06
    pins_next.ale = active && op_reg.kind == OP_ADDR; // RULE_08
    pins_next.we_n = !(strobe && !is_out); // RULE_06 RULE_08 RULE_09
    pins_next.re_n = !(strobe && is_out);
    pins_next.wp_n = ctrl_reg[CTRL_WP]; // RULE_07
    oe_next = active && !is_out; // RULE_09
    io_next = op_reg.data;
  end

  // ----------------------------------------------------------------
  // Bus cycle sequencer
  // ----------------------------------------------------------------
  wire ph_end = ph_reg == 8'h0;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_reg <= S_IDLE;
      op_reg <= '{OP_CMD, 8'h00};
      pend_dout_reg <= 1'b0;
      ph_reg <= 8'h0;
      to_reg <= 24'h0;
      dout_reg <= 8'h0;
      reset_done_reg <= 1'b0;
    end else begin
      ph_reg <= ph_end ? 8'h0 : ph_reg - 8'h1;
      case (state_reg)
        S_IDLE: begin
          if (accept) begin
            op_reg <= need_auto ? '{OP_CMD, CMD_READ} :
              '{sw_cmd ? OP_CMD : sw_addr ? OP_ADDR : sw_din ? OP_DIN : OP_DOUT, wbyte};
            pend_dout_reg <= need_auto;
            ph_reg <= SETUP_CYC;
            // Power-on reset goes out only once the ready line is high
            state_reg <= (sw_cmd && !reset_done_reg) ? S_HOLD : S_SETUP; // RULE_20
          end
        end
        S_HOLD: begin
          ph_reg <= SETUP_CYC;
          if (rb_n) begin
            state_reg <= S_SETUP;
          end
        end
        S_SETUP: begin
          if (ph_end) begin
            ph_reg <= LOW_CYC;
            state_reg <= S_LOW;
          end
        end
        S_LOW: begin
          if (ph_end) begin
            if (is_out) begin
              dout_reg <= io_in;
            end
            ph_reg <= HIGH_CYC;
            state_reg <= S_HIGH;
          end
        end
        S_HIGH: begin
          if (ph_end) begin
            ph_reg <= WB_CYC;
            state_reg <= (op_reg.kind == OP_CMD || op_reg.kind == OP_ADDR) ? S_GAP : S_IDLE;
          end
        end
        S_GAP: begin
          // The ready line is not valid until the write-to-busy time is over
          if (ph_end) begin
            to_reg <= busy_limit;
            if (op_reg.kind == OP_CMD && is_busy_cmd(op_reg.data)) begin
              state_reg <= S_BUSY;
            end else if (pend_dout_reg) begin
              pend_dout_reg <= 1'b0;
              op_reg <= '{OP_DOUT, 8'h00};
              ph_reg <= SETUP_CYC;
              state_reg <= S_SETUP;
            end else begin
              state_reg <= S_IDLE;
            end
          end
        end
        S_BUSY: begin
          to_reg <= (to_reg == 24'h0) ? 24'h0 : to_reg - 24'h1;
          if (rb_n || timeout) begin // RULE_22
            if (op_reg.data == CMD_RESET) begin
              reset_done_reg <= 1'b1;
            end
            state_reg <= S_IDLE;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Software view of the operation in progress
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cur_cmd_reg <= 8'h00;
      addr_idx_reg <= 2'h0;
      col_reg <= 16'h0;
      row_reg <= 16'h0;
      read_pend_reg <= 1'b0;
      last_status_reg <= 1'b0;
      cb_mode_reg <= 1'b0;
      src_par_reg <= 1'b0;
    end else begin
      if (acc_cmd) begin
        cur_cmd_reg <= wbyte;
        addr_idx_reg <= 2'h0;
        last_status_reg <= wbyte == CMD_STATUS;
        if (wbyte == CMD_READ_GO || wbyte == CMD_COPY_READ_GO || wbyte == CMD_GET_FEAT) begin
          read_pend_reg <= 1'b1;
        end else if (wbyte != CMD_STATUS) begin
          read_pend_reg <= 1'b0;
        end
        if (wbyte == CMD_COPY_READ_GO) begin
          cb_mode_reg <= 1'b1;
          src_par_reg <= row_reg[0]; // RULE_05
        end else if (wbyte == CMD_PROG || wbyte == CMD_ERASE || wbyte == CMD_RESET) begin
          cb_mode_reg <= 1'b0;
        end
      end
      if (need_auto && accept) begin
        last_status_reg <= 1'b0;
      end
      if (acc_addr) begin
        addr_idx_reg <= addr_idx_reg + 2'h1;
        case (addr_idx_reg)
          2'h0: col_reg[7:0] <= wbyte;
          2'h1: col_reg[15:8] <= wbyte;
          2'h2: row_reg[7:0] <= wbyte;
          default: row_reg[15:8] <= wbyte;
        endcase
      end else if (acc_din) begin
        col_reg <= col_reg + 16'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Partial program bookkeeping
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pp_row_reg <= 16'h0;
      pp_cnt_reg <= 3'h0;
      load_cnt_reg <= 13'h0;
      main_seg_reg <= 2'h0;
      main_seen_reg <= 1'b0;
      spare_seen_reg <= 1'b0;
    end else begin
      if (col_done && in_prog) begin
        load_cnt_reg <= 13'h0; // RULE_18
        if (!col_seg[2]) begin
          main_seg_reg <= col_seg[1:0]; // RULE_14
        end
      end else if (acc_din && load_cnt_reg != '1) begin
        load_cnt_reg <= load_cnt_reg + 13'h1;
      end
      if (acc_din) begin
        // Main and spare of a segment are scrambled apart, so both must land together
        if (seg_spare) begin
          spare_seen_reg <= 1'b1; // RULE_13 RULE_16
        end else begin
          main_seen_reg <= 1'b1;
        end
      end
      if (acc_cmd && wbyte == CMD_PROG) begin
        main_seen_reg <= 1'b0;
        spare_seen_reg <= 1'b0;
        load_cnt_reg <= 13'h0;
      end
      if (prog_go) begin
        pp_row_reg <= row_reg;
        pp_cnt_reg <= same_page ? pp_cnt_reg + 3'h1 : 3'h1; // RULE_01
      end
    end
  end

  // ----------------------------------------------------------------
  // Control, errors and outputs
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= CTRL_RESET;
      err_reg <= '0;
      rdata <= 32'h0;
      pins <= '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
      io_out <= 8'h00;
      io_oe <= 1'b0;
    end else begin
      if (wr && addr == REG_CTRL) begin
        ctrl_reg <= wdata[2:0];
      end
      // A new error in the same cycle as its clear stays set
      err_reg <= (err_reg & ~err_clr) | err_set;
      rdata <= rd ? rd_mux : 32'h0;
      pins <= pins_next;
      io_out <= io_next;
      io_oe <= oe_next;
    end
  end
endmodule

// File: hdl/flash_host_pkg.sv
package flash_host_pkg;
  // ----------------------------------------------------------------
  // Clock and link timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int T_WP_NS = 10;
  localparam int T_WH_NS = 7;
  localparam int T_REA_NS = 16;
  localparam int T_WB_NS = 100;
  localparam logic [7:0] SETUP_CYC = 8'h01;
  localparam logic [7:0] WP_CYC = 8'((T_WP_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] REA_CYC = 8'((T_REA_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] LOW_CYC = (REA_CYC > WP_CYC) ? REA_CYC : WP_CYC;
  localparam logic [7:0] HIGH_CYC = 8'((T_WH_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] WB_CYC = 8'((T_WB_NS * CLK_MHZ + 999) / 1000);
  // Busy limits, microseconds and cycles
  localparam int T_FEAT_US = 1;
  localparam int T_RST_US = 5;
  localparam int T_OTP_US = 800;
  localparam int T_PROG_US = 600;
  localparam int T_BERS_US = 10000;
  localparam int T_R_US = 350;
  localparam logic [23:0] FEAT_CYC = 24'(T_FEAT_US * CLK_MHZ);
  localparam logic [23:0] RST_CYC = 24'(T_RST_US * CLK_MHZ);
  localparam int OTP_CYC = T_OTP_US * CLK_MHZ;
  localparam int PROG_CYC = T_PROG_US * CLK_MHZ;
  localparam int BERS_CYC = T_BERS_US * CLK_MHZ;
  localparam int READ_CYC = T_R_US * CLK_MHZ;
  // ----------------------------------------------------------------
  // Page geometry and program limits
  // ----------------------------------------------------------------
  localparam int PP_MAX = 4;
  localparam int SMALL_MIN = 4;
  localparam int ADDR_BITS = 27;
  localparam int COL_BYTES = 2;
  localparam int MAIN_BYTES = 4096;
  localparam int SEG_BYTES = 1024;
  localparam int SPARE_SEG_BYTES = 64;
  // ----------------------------------------------------------------
  // Command bytes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_READ = 8'h00;
  localparam logic [7:0] CMD_READ_GO = 8'h30;
  localparam logic [7:0] CMD_COPY_READ_GO = 8'h35;
  localparam logic [7:0] CMD_PROG = 8'h80;
  localparam logic [7:0] CMD_COL_IN = 8'h85;
  localparam logic [7:0] CMD_PROG_GO = 8'h10;
  localparam logic [7:0] CMD_ERASE = 8'h60;
  localparam logic [7:0] CMD_ERASE_GO = 8'hD0;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_SET_FEAT = 8'hEF;
  localparam logic [7:0] CMD_GET_FEAT = 8'hEE;
  localparam logic [7:0] CMD_RESET = 8'hFF;
  // ----------------------------------------------------------------
  // Software register map and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_DATA = 8'h08;
  localparam logic [7:0] REG_RDREQ = 8'h0C;
  localparam logic [7:0] REG_CTRL = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam int CTRL_WP = 0;
  localparam int CTRL_OTP = 1;
  localparam int CTRL_CE = 2;
  localparam logic [2:0] CTRL_RESET = 3'h4;
  localparam int ERR_LSB = 8;
  localparam int NUM_ERR = 8;
  localparam int ERR_NOT_RESET = 0;
  localparam int ERR_WP = 1;
  localparam int ERR_PP = 2;
  localparam int ERR_SIZE = 3;
  localparam int ERR_ALIGN = 4;
  localparam int ERR_PAIR = 5;
  localparam int ERR_PARITY = 6;
  localparam int ERR_TIMEOUT = 7;

  typedef enum logic [1:0] {OP_CMD, OP_ADDR, OP_DIN, OP_DOUT} op_kind_t;
  typedef struct packed {
    op_kind_t kind;
    logic [7:0] data;
  } op_t;
  typedef struct packed {
    logic ce_n;
    logic cle;
    logic ale;
    logic we_n;
    logic re_n;
    logic wp_n;
  } pins_t;
endpackage

// File: verif/flash_host_props.sv
`timescale 1ns/1ps
module flash_host_props
  import flash_host_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  // Flash pins
  input wire pins_t pins,
  input wire logic [7:0] io_out,
  input wire logic io_oe,
  input wire logic [7:0] io_in,
  input wire logic rb_n
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // Helper: has any command been latched since reset
  // ----------------------------------------------------------------
  logic cmd_seen;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cmd_seen <= 1'b0;
    end else if ($rose(pins.we_n) && pins.cle) begin
      cmd_seen <= 1'b1;
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_idle_after_reset;
    $fell(rst) |-> pins.we_n && pins.re_n && !pins.cle && !pins.ale && !io_oe;
  endproperty
  property p_latch_exclusive;
    !(pins.cle && pins.ale);
  endproperty
  property p_strobe_width;
    $fell(pins.we_n) |-> (!pins.we_n) [*5] ##1 pins.we_n;
  endproperty
  property p_write_drives_bus;
    !pins.we_n |-> io_oe && pins.re_n && !pins.ce_n;
  endproperty
  property p_cmd_hold;
    $rose(pins.we_n) && pins.cle |-> io_oe ##1 (pins.cle && $stable(io_out));
  endproperty
  property p_addr_hold;
    $rose(pins.we_n) && pins.ale |-> io_oe ##1 (pins.ale && $stable(io_out));
  endproperty
  property p_modify_lock;
    $rose(pins.we_n) && pins.cle && (io_out == CMD_PROG || io_out == CMD_ERASE) |-> pins.wp_n;
  endproperty
  property p_first_cmd_reset;
    $rose(pins.we_n) && pins.cle && !cmd_seen |-> io_out == CMD_RESET;
  endproperty
  property p_read_released;
    !pins.re_n |-> !io_oe && !pins.cle && !pins.ale && !pins.ce_n;
  endproperty
  property p_rdata_quiet;
    !$past(rd) |-> rdata == 32'h0;
  endproperty
  a_idle_after_reset: assert property (p_idle_after_reset) else $error("pins not idle after reset");
  a_latch_exclusive: assert property (p_latch_exclusive) else $error("both latches high");
  a_strobe_width: assert property (p_strobe_width) else $error("write strobe width wrong");
  a_write_drives_bus: assert property (p_write_drives_bus) else $error("write strobe without bus");
  a_cmd_hold: assert property (p_cmd_hold) else $error("command not held");
  a_addr_hold: assert property (p_addr_hold) else $error("address not held");
  a_modify_lock: assert property (p_modify_lock) else $error("modify with lock low");
  a_first_cmd_reset: assert property (p_first_cmd_reset) else $error("first command not reset");
  a_read_released: assert property (p_read_released) else $error("read strobe with bus driven");
  a_rdata_quiet: assert property (p_rdata_quiet) else $error("read data outside slot");
  c_cmd: cover property ($rose(pins.we_n) && pins.cle);
  c_addr: cover property ($rose(pins.we_n) && pins.ale);
  c_dout: cover property ($fell(pins.re_n));
  c_busy: cover property ($fell(rb_n));
endmodule

// File: verif/flash_dev_model.sv
`timescale 1ns/1ps
module flash_dev_model
  import flash_host_pkg::*;
#(
  parameter logic [7:0] STAT_BYTE = 8'hE0,
  parameter logic [7:0] PAGE_BYTE = 8'h3C
) (
  // Clock and busy length
  input wire logic sys_clk,
  input wire logic [15:0] busy_cyc,
  // Flash pins
  input wire pins_t pins,
  input wire logic [7:0] io_out,
  output logic [7:0] io_in,
  output logic rb_n,
  // Observed traffic
  output logic [7:0] last_cmd,
  output logic [31:0] last_addr,
  output logic [31:0] last_din
);
  logic we_q;
  logic [15:0] busy;
  logic [7:0] io_last;
  wire we_rise = pins.we_n && !we_q && !pins.ce_n && pins.re_n;
  wire modify = (io_out == CMD_PROG) || (io_out == CMD_ERASE);
  wire [7:0] dout = (last_cmd == CMD_STATUS) ? STAT_BYTE : PAGE_BYTE;
  initial begin
    we_q = 1'b1;
    busy = 16'h0;
    io_last = 8'h00;
    last_cmd = 8'h00;
    last_addr = 32'h0;
    last_din = 32'h0;
  end
  always @(posedge sys_clk) begin
    we_q <= pins.we_n;
    if (busy != 16'h0) busy <= busy - 16'h1;
    if (!pins.re_n) io_last <= dout;
    // Modify commands with the lock pin low are ignored
    if (we_rise && pins.cle && !pins.ale && !(modify && !pins.wp_n)) begin
      last_cmd <= io_out;
      if (io_out inside {CMD_READ_GO, CMD_COPY_READ_GO, CMD_PROG_GO, CMD_ERASE_GO, CMD_RESET,
                         CMD_SET_FEAT, CMD_GET_FEAT}) busy <= busy_cyc;
    end
    if (we_rise && pins.ale && !pins.cle) last_addr <= {io_out, last_addr[31:8]};
    if (we_rise && !pins.ale && !pins.cle && pins.wp_n) last_din <= {io_out, last_din[31:8]};
  end
  // Open-drain line released to its pull-up when idle
  assign rb_n = (busy == 16'h0);
  // Released bus shows the inverse of the last byte, never a stale copy
  assign io_in = (!pins.ce_n && !pins.re_n) ? dout : ~io_last;
endmodule

// File: verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  import flash_host_pkg::*;
  typedef struct {int k; logic [7:0] a; logic [31:0] d; logic [31:0] m; logic [31:0] e;} row_t;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  pins_t pins;
  logic [7:0] io_out, io_in, last_cmd;
  logic io_oe, rb_n;
  logic [31:0] last_addr, last_din, v;
  logic [15:0] busy_cyc = 16'h0064;
  int errors = 0;
  int total_checks = 0;
  always #2 sys_clk = ~sys_clk;
  flash_host #(.PROG_TO_CYC(200), .OTP_TO_CYC(300), .ERASE_TO_CYC(400), .READ_TO_CYC(200)) flash_host_i (
    .sys_clk(sys_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .pins(pins), .io_out(io_out), .io_oe(io_oe), .io_in(io_in), .rb_n(rb_n));
  flash_dev_model flash_dev_model_i (
    .sys_clk(sys_clk), .busy_cyc(busy_cyc), .pins(pins), .io_out(io_out), .io_in(io_in), .rb_n(rb_n),
    .last_cmd(last_cmd), .last_addr(last_addr), .last_din(last_din));
  // ----------------------------------------------------------------
  // Bus tasks and checks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Software must see the sequencer idle before the next flash request
  task automatic wr_idle(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] s;
    int n;
    reg_wr(a, d);
    n = 0;
    s = 32'h1;
    while (s[0] !== 1'b0 && n < 2000) begin
      reg_rd(REG_STATUS, s);
      n++;
    end
    if (n == 2000) errors++;
  endtask
  task automatic stat_is(input logic [31:0] m, input logic [31:0] e);
    reg_rd(REG_STATUS, v);
    chk(v & m, e);
  endtask
  task automatic prog(input logic [15:0] row, input logic [15:0] col, input int n);
    wr_idle(REG_CMD, {24'h0, CMD_PROG});
    wr_idle(REG_ADDR, {24'h0, col[7:0]});
    wr_idle(REG_ADDR, {24'h0, col[15:8]});
    wr_idle(REG_ADDR, {24'h0, row[7:0]});
    wr_idle(REG_ADDR, {24'h0, row[15:8]});
    for (int i = 0; i < n; i++) wr_idle(REG_DATA, 32'h11 * 32'(i + 1));
    wr_idle(REG_CMD, {24'h0, CMD_PROG_GO});
  endtask
  function automatic logic [31:0] mdl(input logic [31:0] s);
    return (s == 0) ? {24'h0, last_cmd} : (s == 1) ? last_addr : last_din;
  endfunction
  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Ordinary cases: kind 0 write, 1 read masked, 2 model traffic
  // ----------------------------------------------------------------
  row_t rows[] = '{
    '{0, REG_CTRL, 32'h5, 0, 0}, '{0, REG_CMD, 32'h80, 0, 0},
    '{0, REG_ADDR, 32'h00, 0, 0}, '{0, REG_ADDR, 32'h00, 0, 0}, '{0, REG_ADDR, 32'h34, 0, 0},
    '{0, REG_ADDR, 32'h12, 0, 0}, '{0, REG_DATA, 32'h11, 0, 0}, '{0, REG_DATA, 32'h22, 0, 0},
    '{0, REG_DATA, 32'h33, 0, 0}, '{0, REG_DATA, 32'h44, 0, 0}, '{0, REG_CMD, 32'h10, 0, 0},
    '{2, 0, 1, 0, 32'h12340000}, '{2, 0, 2, 0, 32'h44332211}, '{2, 0, 0, 0, 32'h10},
    '{1, REG_STATUS, 0, 32'h76, 32'h16}, '{0, REG_CMD, 32'h70, 0, 0}, '{0, REG_RDREQ, 0, 0, 0},
    '{1, REG_DATA, 0, 32'hFF, 32'hE0}, '{0, REG_CMD, 32'h00, 0, 0}, '{0, REG_ADDR, 32'h00, 0, 0},
    '{0, REG_ADDR, 32'h00, 0, 0}, '{0, REG_ADDR, 32'h34, 0, 0}, '{0, REG_ADDR, 32'h12, 0, 0},
    '{0, REG_CMD, 32'h30, 0, 0}, '{0, REG_CMD, 32'h70, 0, 0}, '{0, REG_RDREQ, 0, 0, 0},
    '{2, 0, 0, 0, 32'h00}, '{1, REG_DATA, 0, 32'hFF, 32'h3C}, '{1, 8'h18, 0, 32'hFFFFFFFF, 0}};
  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    reg_rd(REG_CTRL, v);
    chk(v, 32'h4);
    wr_idle(REG_CMD, {24'h0, CMD_STATUS});
    stat_is(32'h100, 32'h100);
    chk(mdl(0), 32'h0);
    wr_idle(REG_STATUS, 32'hFF00);
    wr_idle(REG_CMD, {24'h0, CMD_RESET});
    stat_is(32'hFF06, 32'h6);
    chk(mdl(0), {24'h0, CMD_RESET});
    foreach (rows[i]) begin
      if (rows[i].k == 0) wr_idle(rows[i].a, rows[i].d);
      else if (rows[i].k == 1) begin
        reg_rd(rows[i].a, v);
        chk(v & rows[i].m, rows[i].e);
      end else chk(mdl(rows[i].d), rows[i].e);
    end
    for (int i = 0; i < 3; i++) prog(16'h1234, 16'h0000, 4);
    stat_is(32'hFF70, 32'h2040);
    prog(16'h1234, 16'h0000, 4);
    stat_is(32'h400, 32'h400);
    wr_idle(REG_STATUS, 32'hFF00);
    stat_is(32'hFF00, 32'h0);
    prog(16'h0056, 16'h0002, 4);
    stat_is(32'h1000, 32'h1000);
    prog(16'h0078, 16'h0000, 2);
    stat_is(32'h800, 32'h800);
    wr_idle(REG_CMD, {24'h0, CMD_STATUS});
    wr_idle(REG_CTRL, 32'h4);
    wr_idle(REG_CMD, {24'h0, CMD_PROG});
    stat_is(32'h200, 32'h200);
    chk(mdl(0), {24'h0, CMD_STATUS});
    for (int j = 0; j < 2; j++) begin
      busy_cyc <= j ? 16'd400 : 16'd100;
      wr_idle(REG_STATUS, 32'hFF00);
      wr_idle(REG_CMD, {24'h0, CMD_SET_FEAT});
      stat_is(32'h8000, j ? 32'h8000 : 32'h0);
      repeat (450) @(posedge sys_clk);
    end
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    reg_rd(REG_CTRL, v);
    chk(v, 32'h4);
    stat_is(32'h4, 32'h0);
    tally_and_finish();
  end
  initial begin
    #200000;
    errors++;
    tally_and_finish();
  end
endmodule
bind flash_host flash_host_props flash_host_props_i (
  .sys_clk(sys_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .pins(pins), .io_out(io_out), .io_oe(io_oe), .io_in(io_in), .rb_n(rb_n));
